//--- core/sarc_params.svh
// timing counts and field constants for the converter readout control
`ifndef SARC_PARAMS_SVH
`define SARC_PARAMS_SVH
`define SARC_CLK_PERIOD_NS     8
`define SARC_RESULT_W          16
`define SARC_HALF_W            8
`define SARC_FIFO_DEPTH        16
`define SARC_CONV_MIN_NS       340
`define SARC_BUSY_MAX_NS       370
`define SARC_ACQ_MIN_NS        100
`define SARC_ABORT_MIN_NS      60
`define SARC_ABORT_MAX_NS      340
// busy-high length: longest time rounds down
`define SARC_CONV_CYC          (`SARC_BUSY_MAX_NS / `SARC_CLK_PERIOD_NS)
// least times round up
`define SARC_ACQ_CYC           ((`SARC_ACQ_MIN_NS + `SARC_CLK_PERIOD_NS - 1) / `SARC_CLK_PERIOD_NS)
`define SARC_ABORT_MIN_CYC     ((`SARC_ABORT_MIN_NS + `SARC_CLK_PERIOD_NS - 1) / `SARC_CLK_PERIOD_NS)
`define SARC_ABORT_MAX_CYC     (`SARC_ABORT_MAX_NS / `SARC_CLK_PERIOD_NS)
`define SARC_LOW_FILL          8'hff
`define SARC_RESET_RESULT      16'h0000
`endif

//--- core/sarc_pkg.sv
// types for the converter readout control
package sarc_pkg;
  typedef enum logic [1:0] {
    SARC_IDLE,
    SARC_ACQUIRE,
    SARC_CONVERT
  } sarc_phase_t;
endpackage : sarc_pkg

//--- core/sarc_fifo_if.sv
// handshake bundle between the converter core and the result fifo
`timescale 1ns/10ps
interface sarc_fifo_if #(parameter int WIDTH = 16);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sarc_fifo_if

//--- core/sarc_fifo.sv
// parameterised result fifo with valid and ready on both sides
`timescale 1ns/10ps
module sarc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  sarc_fifo_if.snk              wr,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic [AW:0]   count;
  } sarc_fifo_state_t;
  sarc_fifo_state_t st;
  sarc_fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign wr.ready  = (st.count != DEPTH[AW:0]);
  assign out_valid = (st.count != '0);
  assign push      = wr.valid && wr.ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[st.rd_ptr];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wr_ptr] <= wr.data;
    end
  end
endmodule : sarc_fifo

//--- core/sarc_core.sv
// conversion control and parallel result readout for the sar converter
//
// Contract
// - convert strobe fall with chip select low ends acquisition, holds, starts conversion.
// - chip select falling edge starts the sampler acquisition period.
// - busy rises within 30 ns (5 V) or 40 ns (3 V) of strobe fall.
// - busy high for whole conversion, 340 to 370 ns, never over 370 ns.
// - busy drops within 5 ns (5 V) or 10 ns (3 V) of conversion end.
// - busy low at least 100 ns acquisition before the next conversion.
// - new result msbs valid within 10 ns (5 V) or 20 ns after end.
// - previous result stays latched until the minimum conversion time.
// - select and read low enable the bus with the latched result.
// - read or select high puts the bus in three-state within 20/30 ns.
// - half-select low gives bits 15..0; high gives bits 7..0 on pins 15..8.
// - half-select high drives all ones on the lower eight pins.
// - half-select change shows new data within 2..20 ns; changes 50 ns apart.
// - strobe fall or select fall 60..340 ns after start aborts conversion.
// - reset low aborts any conversion and clears the output latches.
// - sampling starts at busy fall with select low, else select fall.
// - reset held 25 ns; abort within 50 ns; resume within 20 ns.
`timescale 1ns/10ps
`include "sarc_params.svh"
module sarc_core #(
  parameter int RESULT_W   = `SARC_RESULT_W,
  parameter int FIFO_DEPTH = `SARC_FIFO_DEPTH
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                reset_n,
  input  wire logic                chip_select_n,
  input  wire logic                convert_strobe_n,
  input  wire logic                read_strobe_n,
  input  wire logic                half_select,
  output logic                     busy,
  output logic [RESULT_W-1:0]      result_bus_pins_o,
  output logic [RESULT_W-1:0]      result_bus_pins_oe_n,
  output logic                     sample_hold,
  input  wire logic [RESULT_W-1:0] sar_code,
  output logic                     code_valid,
  input  wire logic                code_ready,
  output logic [RESULT_W-1:0]      code_data,
  output logic                     sample_dropped
);
  localparam logic [5:0] CONV_CYC  = 6'(`SARC_CONV_CYC);
  localparam logic [5:0] ACQ_CYC   = 6'(`SARC_ACQ_CYC);
  localparam logic [5:0] AB_MIN    = 6'(`SARC_ABORT_MIN_CYC);
  localparam logic [5:0] AB_MAX    = 6'(`SARC_ABORT_MAX_CYC);
  localparam int         HW        = `SARC_HALF_W;

  typedef struct packed {
    sarc_pkg::sarc_phase_t phase;
    logic [5:0]            timer;
    logic [5:0]            acq_timer;
    logic                  cs_n_q;
    logic                  cv_n_q;
    logic                  busy;
    logic                  hold;
    logic [RESULT_W-1:0]   latch;
    logic [RESULT_W-1:0]   bus_o;
    logic                  bus_en;
    logic                  dropped;
  } sarc_state_t;

  sarc_state_t st;
  sarc_state_t next_st;
  sarc_fifo_if #(.WIDTH(RESULT_W)) res_q ();

  logic cs_fall;
  logic cv_fall;
  logic conv_done;
  logic in_reset;
  logic start_ok;
  logic abort_edge;

  // reset pin treated as synchronous like every other pin
  assign in_reset   = sys_rst || !reset_n;
  assign cs_fall    = st.cs_n_q && !chip_select_n;
  assign cv_fall    = st.cv_n_q && !convert_strobe_n && !chip_select_n;
  assign conv_done  = (st.phase == sarc_pkg::SARC_CONVERT) && (st.timer == CONV_CYC - 6'h01);
  // a start is taken only after the acquisition interval has run out
  assign start_ok   = (st.acq_timer >= ACQ_CYC);
  // an abort edge inside the window ends the running conversion with no result
  assign abort_edge = (st.phase == sarc_pkg::SARC_CONVERT) && (cv_fall || cs_fall)
                      && (st.timer >= AB_MIN) && (st.timer <= AB_MAX);

  assign res_q.valid = conv_done && !abort_edge;
  assign res_q.data  = sar_code;

  always_comb begin
    next_st        = st;
    next_st.cs_n_q = chip_select_n;
    next_st.cv_n_q = convert_strobe_n;
    if (st.acq_timer < ACQ_CYC) begin
      next_st.acq_timer = st.acq_timer + 6'h01;
    end
    case (st.phase)
      sarc_pkg::SARC_IDLE: begin
        next_st.hold = 1'b0;
        if (cs_fall) begin
          next_st.phase     = sarc_pkg::SARC_ACQUIRE;
          next_st.acq_timer = '0;
        end else if (cv_fall && start_ok) begin
          next_st.phase = sarc_pkg::SARC_CONVERT;
          next_st.timer = '0;
          next_st.busy  = 1'b1;
          next_st.hold  = 1'b1;
        end
      end
      sarc_pkg::SARC_ACQUIRE: begin
        next_st.hold = 1'b0;
        if (cv_fall && start_ok) begin
          next_st.phase = sarc_pkg::SARC_CONVERT;
          next_st.timer = '0;
          next_st.busy  = 1'b1;
          next_st.hold  = 1'b1;
        end
      end
      sarc_pkg::SARC_CONVERT: begin
        // fixed-length count from the start edge sets busy width
        next_st.timer = st.timer + 6'h01;
        if (abort_edge) begin
          next_st.phase     = sarc_pkg::SARC_ACQUIRE;
          next_st.busy      = 1'b0;
          next_st.hold      = 1'b0;
          next_st.acq_timer = '0;
        end else if (conv_done) begin
          // busy falls on the same edge that latches the new code
          next_st.busy      = 1'b0;
          next_st.hold      = 1'b0;
          next_st.latch     = sar_code;
          next_st.acq_timer = '0;
          // with select low sampling restarts at busy fall
          next_st.phase     = chip_select_n ? sarc_pkg::SARC_IDLE
                                            : sarc_pkg::SARC_ACQUIRE;
          next_st.dropped   = !res_q.ready;
        end
        // previous latch untouched until the conversion completes
      end
      default: begin
        next_st.phase = sarc_pkg::SARC_IDLE;
      end
    endcase
    // output path: select and read low enable the bus
    next_st.bus_en = !chip_select_n && !read_strobe_n;
    if (half_select) begin
      // lower byte folded onto the upper pins, ones below
      next_st.bus_o = {st.latch[HW-1:0], `SARC_LOW_FILL};
    end else begin
      next_st.bus_o = st.latch;
    end
    if (conv_done && !abort_edge) begin
      next_st.bus_o = half_select ? {sar_code[HW-1:0], `SARC_LOW_FILL} : sar_code;
    end
  end

  always_ff @(posedge clk) begin
    if (in_reset) begin
      // abort and clear the output latches regardless of select
      st        <= '0;
      st.phase  <= sarc_pkg::SARC_IDLE;
      st.latch  <= `SARC_RESET_RESULT;
      // select history starts low so select tied low gives no false fall after reset
      st.cs_n_q <= 1'b0;
      st.cv_n_q <= 1'b1;
      st.acq_timer <= ACQ_CYC;
    end else begin
      st <= next_st;
    end
  end

  assign busy                 = st.busy;
  assign sample_hold          = st.hold;
  assign result_bus_pins_o    = st.bus_o;
  assign result_bus_pins_oe_n = {RESULT_W{!st.bus_en}};
  assign sample_dropped       = st.dropped;

  // results also stream out; a full queue drops the sample and flags it
  sarc_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (in_reset),
    .wr        (res_q.snk),
    .out_valid (code_valid),
    .out_ready (code_ready),
    .out_data  (code_data)
  );
endmodule : sarc_core

//--- testbench/sarc_core_assertions.sv
// port-level checks on the converter readout control
`timescale 1ns/10ps
module sarc_core_assertions #(
  parameter int RESULT_W = 16
) (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                reset_n,
  input wire logic                chip_select_n,
  input wire logic                convert_strobe_n,
  input wire logic                read_strobe_n,
  input wire logic                half_select,
  input wire logic                busy,
  input wire logic [RESULT_W-1:0] result_bus_pins_o,
  input wire logic [RESULT_W-1:0] result_bus_pins_oe_n
);
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  logic       cs_q;
  // lo_cnt starts at 20, above both acquisition limits: acquisition counts as met after reset
  // a select fall restarts acquisition, so it clears the count as well
  always_ff @(posedge clk) begin
    if (sys_rst || !reset_n) begin
      hi_cnt <= 8'h00;
      lo_cnt <= 8'h14;
      cs_q   <= 1'b0;
    end else begin
      cs_q   <= chip_select_n;
      hi_cnt <= busy ? hi_cnt + 8'h01 : 8'h00;
      if (busy || (cs_q && !chip_select_n)) begin
        lo_cnt <= 8'h00;
      end else begin
        lo_cnt <= (lo_cnt == 8'hff) ? lo_cnt : lo_cnt + 8'h01;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || !reset_n);
  a_busy_rise: assert property (
    $fell(convert_strobe_n) && !chip_select_n && !busy && lo_cnt >= 8'h0e |-> ##[1:3] busy)
    else $error("no busy after start");
  a_busy_max: assert property (busy |-> hi_cnt < 8'h2e)
    else $error("busy too long");
  a_busy_hold: assert property ($rose(busy) |-> busy [*6])
    else $error("busy too short");
  a_acq_min: assert property ($rose(busy) |-> $past(lo_cnt) >= 8'h0c)
    else $error("acquisition cut short");
  a_abort_drop: assert property (
    busy && hi_cnt >= 8'h0a && hi_cnt <= 8'h26 && $fell(convert_strobe_n) && !chip_select_n
    |-> ##[1:2] !busy) else $error("abort ignored");
  a_bus_on: assert property (
    !read_strobe_n && !chip_select_n |=> result_bus_pins_oe_n == {RESULT_W{1'b0}})
    else $error("bus not driven");
  a_bus_off: assert property (read_strobe_n || chip_select_n |=> &result_bus_pins_oe_n)
    else $error("bus not released");
  a_low_fill: assert property (
    $past(half_select) && !result_bus_pins_oe_n[0] |-> result_bus_pins_o[7:0] == 8'hff)
    else $error("low pins not ones");
endmodule : sarc_core_assertions

//--- testbench/sarc_host_model.sv
// host side: analog code source and resolved level of the data pins
`timescale 1ns/10ps
module sarc_host_model (
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic [15:0] bus_o,
  input  wire logic [15:0] bus_oe_n,
  output logic      [15:0] sar_code,
  output logic      [15:0] bus_level
);
  logic        busy_q = 1'b0;
  logic [15:0] last = 16'h0000;
  initial sar_code = 16'h3c5a;
  always @(posedge clk) begin
    busy_q <= busy;
    // code moves only one cycle after busy falls, so each result is known in advance
    if (busy_q && !busy) sar_code <= sar_code + 16'h0b1d;
    for (int i = 0; i < 16; i++) if (!bus_oe_n[i]) last[i] <= bus_o[i];
  end
  // a released pin shows the inverse of its last level, never a stale copy
  always_comb for (int i = 0; i < 16; i++) bus_level[i] = bus_oe_n[i] ? ~last[i] : bus_o[i];
endmodule : sarc_host_model

//--- testbench/testbench.sv
// self-checking bench for the converter readout control
`timescale 1ns/10ps
module testbench;
  logic        clk, sys_rst, reset_n, cs_n, conv_n, rd_n, half_select, code_ready;
  logic        busy, code_valid, sample_dropped;
  logic [15:0] bus_o, bus_oe_n, sar_code, bus_level, code_data, c;
  logic [15:0] q[$];
  int          n_errors = 0;
  int          checked = 0;
  int          bw = 0;
  int          cyc = 0;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  sarc_core i_sarc_core (.clk(clk), .sys_rst(sys_rst), .reset_n(reset_n),
    .chip_select_n(cs_n), .convert_strobe_n(conv_n), .read_strobe_n(rd_n),
    .half_select(half_select), .busy(busy), .result_bus_pins_o(bus_o),
    .result_bus_pins_oe_n(bus_oe_n), .sample_hold(), .sar_code(sar_code),
    .code_valid(code_valid), .code_ready(code_ready), .code_data(code_data),
    .sample_dropped(sample_dropped));
  sarc_host_model i_sarc_host_model (.clk(clk), .busy(busy), .bus_o(bus_o),
    .bus_oe_n(bus_oe_n), .sar_code(sar_code), .bus_level(bus_level));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse;
    bw = 0;
    @(posedge clk);
    conv_n <= 1'b0;
    repeat (3) @(posedge clk); // strobe low at least 20 ns
    conv_n <= 1'b1;
  endtask : pulse
  task automatic settle(input int n);
    int t;
    t = 0;
    repeat (16) @(posedge clk);
    #1;
    while (busy !== 1'b0 && t < 80) begin
      @(posedge clk);
      #1;
      t++;
    end
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic rd_word(input logic hs, input logic [15:0] exp);
    @(posedge clk);
    half_select <= hs; // reads begin long after any strobe fall
    rd_n <= 1'b0;
    repeat (7) @(posedge clk); // read low at least 50 ns
    #1 chk(bus_level, exp);
    @(posedge clk);
    rd_n <= 1'b1;
    repeat (7) @(posedge clk); // gap before next strobe or byte change
    #1 chk(bus_oe_n, 16'hffff);
  endtask : rd_word
  task automatic t_basic;
    c = sar_code;
    pulse();
    settle(1);
    chk(bw[15:0], 16'h002e);
    pulse();
    settle(14);
    chk(bw[15:0], 16'h0000);
    rd_word(1'b0, c);
    rd_word(1'b1, {c[7:0], 8'hff});
    $display("t_basic done");
  endtask : t_basic
  task automatic t_abort;
    pulse();
    repeat (16) @(posedge clk);
    #1 pulse();
    settle(14);
    chk({15'h0000, bw < 4}, 16'h0001);
    rd_word(1'b0, c);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_reset;
    pulse();
    repeat (10) @(posedge clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk); // low longer than 25 ns
    reset_n <= 1'b1;
    @(posedge clk);
    #1 chk({13'h0000, busy, code_valid, bus_oe_n[0]}, 16'h0001);
    settle(14);
    rd_word(1'b0, 16'h0000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fill;
    for (int i = 0; i < 17; i++) begin
      c = sar_code;
      if (i < 16) q.push_back(c);
      pulse();
      settle(14);
    end
    chk({15'h0000, sample_dropped}, 16'h0001);
    @(posedge clk);
    code_ready <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      #1 chk(code_data, q.pop_front());
      @(posedge clk);
    end
    #1 chk({15'h0000, code_valid}, 16'h0000);
    $display("t_fill done");
  endtask : t_fill
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    bw <= bw + int'(busy === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    // select held low throughout, so it always leads the strobe
    {sys_rst, reset_n, cs_n, conv_n, rd_n, half_select, code_ready} = 7'h6c;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 t_basic();
    t_abort();
    t_reset();
    t_fill();
    final_report();
  end
endmodule : testbench
bind sarc_core sarc_core_assertions #(.RESULT_W(RESULT_W)) i_sarc_core_assertions (
  .clk(clk), .sys_rst(sys_rst), .reset_n(reset_n), .chip_select_n(chip_select_n),
  .convert_strobe_n(convert_strobe_n), .read_strobe_n(read_strobe_n),
  .half_select(half_select), .busy(busy), .result_bus_pins_o(result_bus_pins_o),
  .result_bus_pins_oe_n(result_bus_pins_oe_n));
